// ==== logic/flr_cfg.svh ====
// Constants for the flash LED configuration register bank.
// Operation
// - Battery threshold bits 7:5, reset 111 disables.
// - Supply below threshold at start-up halts ramping.
// - Flash pulse: reduce current until supply recovers.
// - Bit 4 blocks flash, else flash starts but holds at zero until supply recovers.
// - Input limit code bits 3:0, reset 0100.
// - Input limit code 1100 disables the limit.
// - Thermal bit: masked level above 130C, else off above 150C.
// - Ramp step dwell 8us down to 1us.
// - Headroom threshold bits 3:2, reset 01.
// - Indicator PWM duty 2/16 to 5/16 at 31.5kHz.
// - Channel-1 flash code, reset 0x33.
// - Channel-2 flash code, reset 0x33.
// - Masked channel-1 code used while mask high.
// - Masked channel-2 code used while mask high.
// - Actual flash code read-only, reset zero.
// - Minimum flash code during low-battery reduction.
// - Mode code 11 means flash mode.
`ifndef FLR_CFG_SVH
`define FLR_CFG_SVH
`define FLR_ADDR_LOW_BATT    8'h04
`define FLR_ADDR_RAMP_IND    8'h05
`define FLR_ADDR_CH1_FLASH   8'h06
`define FLR_ADDR_CH2_FLASH   8'h07
`define FLR_ADDR_CH1_MASKED  8'h08
`define FLR_ADDR_CH2_MASKED  8'h09
`define FLR_ADDR_ACTUAL      8'h0A
`define FLR_ADDR_MINIMUM     8'h0B
`define FLR_RST_LOW_BATT     8'hF4
`define FLR_RST_RAMP_IND     8'h14
`define FLR_RST_LEVEL        8'h33
`define FLR_RST_READBACK     8'h00
`define FLR_THRESH_OFF       3'h7
`define FLR_ILIM_OFF         4'hC
`define FLR_MODE_FLASH       2'h3
`define FLR_MODE_INDICATOR   2'h1
`define FLR_CLK_MHZ          125
`define FLR_STEP_MAX_US      8
`define FLR_PWM_FREQ_HZ      31500
`define FLR_CLK_HZ           125000000
`define FLR_PWM_PERIOD       (`FLR_CLK_HZ / `FLR_PWM_FREQ_HZ)
`define FLR_PWM_SLOTS        16
`define FLR_DUTY_BASE        2
`endif

// ==== logic/flr_pkg.sv ====
// Types shared by the flash LED configuration register bank.
package flr_pkg;
   typedef enum logic [1:0] {FLR_IDLE, FLR_RAMP, FLR_HOLD, FLR_BLOCKED} flr_ramp_e;
   typedef logic [7:0] flr_code_t;
endpackage : flr_pkg

// ==== logic/flr_pwm.sv ====
// Indicator PWM generator with a 2/16 to 5/16 duty.
`timescale 1ns/100ps
`include "flr_cfg.svh"
module flr_pwm
   import flr_pkg::*;
(
   input  wire logic       i_ref_clk,   // Block clock.
   input  wire logic       i_rst_n,     // Asynchronous reset, active low.
   input  wire logic       i_enable,    // Indicator mode active.
   input  wire logic [1:0] i_duty,      // Duty select.
   output logic            o_pwm        // Registered PWM output.
);
   typedef struct packed {
      logic [12:0] cnt;   // Cycle counter within one period.
      logic        pwm;   // Output level.
   } flr_pwm_s;
   flr_pwm_s st;
   flr_pwm_s next_st;
   localparam logic [12:0] PERIOD = 13'(`FLR_PWM_PERIOD);
   localparam logic [12:0] SLOT   = 13'(`FLR_PWM_PERIOD / `FLR_PWM_SLOTS);

   // High for (duty+2) sixteenths of each 31.5 kHz period; integer slot width
   // trades a tiny frequency error for a simple compare.
   always_comb begin
      next_st = st;
      if (!i_enable) begin
         next_st.cnt = '0;
         next_st.pwm = 1'b0;
      end else begin
         next_st.cnt = (st.cnt >= PERIOD - 13'h1) ? 13'h0 : st.cnt + 13'h1;
         next_st.pwm = st.cnt < SLOT * (13'(i_duty) + 13'(`FLR_DUTY_BASE));
      end
   end

   // State register.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign o_pwm = st.pwm;
endmodule : flr_pwm

// ==== logic/flr_ramp.sv ====
// Flash current ramp with low-battery and thermal handling.
`timescale 1ns/100ps
`include "flr_cfg.svh"
module flr_ramp
   import flr_pkg::*;
(
   input  wire logic       i_ref_clk,      // Block clock.
   input  wire logic       i_rst_n,        // Asynchronous reset, active low.
   input  wire logic       i_flash,        // Flash mode requested.
   input  wire logic       i_low_batt,     // Supply below threshold (already gated).
   input  wire logic       i_block_flash,  // Stay off on low supply before flash.
   input  wire logic       i_thermal_low,  // Thermal fallback to masked level.
   input  wire logic       i_thermal_off,  // Thermal shutdown.
   input  wire logic       i_tx_mask,      // Transmit mask input.
   input  wire logic [2:0] i_step_sel,     // Ramp step time code.
   input  wire logic [7:0] i_target,       // Normal flash target.
   input  wire logic [7:0] i_masked,       // Masked flash target.
   output logic      [7:0] o_level,        // Present drive code.
   output logic      [7:0] o_minimum       // Lowest code reached by reduction.
);
   typedef struct packed {
      flr_ramp_e   state;  // Ramp phase.
      logic [10:0] tmr;    // Step dwell counter.
      flr_code_t   level;  // Present code.
      flr_code_t   minv;   // Lowest reduced code.
   } flr_ramp_s;
   flr_ramp_s st;
   flr_ramp_s next_st;
   flr_code_t goal;
   logic [10:0] dwell;

   // Dwell is (8 - code) microseconds expressed in clocks.
   always_comb begin
      dwell = 11'((`FLR_STEP_MAX_US - 32'(i_step_sel)) * `FLR_CLK_MHZ - 1);
      if (i_tx_mask || i_thermal_low || (i_low_batt && !i_block_flash)) begin
         goal = i_masked;
      end else begin
         goal = i_target;
      end
   end

   // Ramp sequencer: one code per dwell, reduce on low supply during flash.
   always_comb begin
      next_st = st;
      next_st.tmr = (st.tmr == 11'h0) ? dwell : st.tmr - 11'h1;
      case (st.state)
         FLR_IDLE: begin
            next_st.level = 8'h00;
            if (i_flash && !i_thermal_off) begin
               if (i_low_batt && i_block_flash) begin
                  next_st.state = FLR_BLOCKED;
               end else begin
                  next_st.state = FLR_RAMP;
                  next_st.minv  = 8'hFF;
               end
            end
         end
         FLR_RAMP: begin
            if (i_low_batt) begin
               next_st.state = FLR_HOLD;
            end else if (st.tmr == 11'h0) begin
               if (st.level < goal) next_st.level = st.level + 8'h01;
               else begin
                  // A lowered target is reached from the hold phase, one code per dwell.
                  next_st.state = FLR_HOLD;
               end
            end
         end
         FLR_HOLD: begin
            if (st.tmr == 11'h0) begin
               if (i_low_batt && st.level != 8'h00) begin
                  next_st.level = st.level - 8'h01;
                  if (st.level - 8'h01 < st.minv) next_st.minv = st.level - 8'h01;
               end else if (!i_low_batt && st.level > goal) begin
                  // Step down toward a lower target so the LED never jumps hard.
                  next_st.level = st.level - 8'h01;
               end else if (!i_low_batt && st.level < goal) begin
                  // Climb back once the mask is released or the supply recovers.
                  next_st.level = st.level + 8'h01;
               end
            end
         end
         FLR_BLOCKED: next_st.level = 8'h00;
         default: next_st.state = FLR_IDLE;
      endcase
      if (!i_flash || i_thermal_off) begin
         next_st.state = FLR_IDLE;
         next_st.level = 8'h00;
      end
   end

   // State register.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '{state: FLR_IDLE, tmr: 11'h0, level: 8'h00, minv: 8'hFF};
      end else begin
         st <= next_st;
      end
   end
   assign o_level   = st.level;
   assign o_minimum = (st.minv == 8'hFF) ? `FLR_RST_READBACK : st.minv;
endmodule : flr_ramp

// ==== logic/flr_regs.sv ====
// Top of the flash LED configuration register bank.
`timescale 1ns/100ps
`include "flr_cfg.svh"
module flr_regs
   import flr_pkg::*;
(
   input  wire logic       i_ref_clk,           // Block clock, 125 MHz.
   input  wire logic       i_rst_n,             // Asynchronous reset, active low.
   input  wire logic       i_wr_en,             // Register write strobe.
   input  wire logic       i_rd_en,             // Register read strobe.
   input  wire logic [7:0] i_addr,              // Register address.
   input  wire logic [7:0] i_wr_data,           // Write data.
   output logic      [7:0] o_rd_data,           // Registered read data.
   input  wire logic [1:0] i_led_mode_sel,      // Device mode from mode register.
   input  wire logic       i_tx_mask,           // Transmit mask input.
   input  wire logic       i_vin_below_thresh,  // Comparator: supply under threshold.
   input  wire logic       i_tj_over_130,       // Junction above 130 C.
   input  wire logic       i_tj_over_150,       // Junction above 150 C.
   output logic [2:0]      o_battery_threshold_sel, // To supply comparator.
   output logic            o_low_batt_active,   // Low-supply handling in force.
   output logic [3:0]      o_input_current_limit, // Input limit code.
   output logic            o_input_limit_enable, // Input limit active.
   output logic [1:0]      o_headroom_threshold, // Headroom threshold code.
   output logic [7:0]      o_chan1_drive,       // Channel-1 drive code.
   output logic [7:0]      o_chan2_drive,       // Channel-2 drive code.
   output logic            o_indicator_pwm      // Indicator PWM gate.
);
   typedef struct packed {
      logic [7:0] low_battery_config;       // Threshold, block bit, limit code.
      logic [7:0] ramp_indicator_config;    // Thermal, step, headroom, duty.
      logic [7:0] chan1_flash_level;        // Normal channel-1 code.
      logic [7:0] chan2_flash_level;        // Normal channel-2 code.
      logic [7:0] chan1_masked_flash_level; // Masked channel-1 code.
      logic [7:0] chan2_masked_flash_level; // Masked channel-2 code.
      logic [7:0] rd_data;                  // Read data register.
   } flr_regs_s;
   flr_regs_s st;
   flr_regs_s next_st;
   logic       flash_mode;
   logic       low_batt;
   logic [7:0] lvl1;
   logic [7:0] lvl2;
   logic [7:0] min1;
   logic [7:0] actual_flash_code;
   logic [7:0] minimum_flash_code;

   // Mode decode and gated supply comparison.
   always_comb begin
      flash_mode = (i_led_mode_sel == `FLR_MODE_FLASH);
      // Code 111 switches the threshold off so the comparator is ignored.
      low_batt = i_vin_below_thresh &&
                 (st.low_battery_config[7:5] != `FLR_THRESH_OFF);
   end

   // One ramp engine per channel; both share the step and safety controls.
   flr_ramp u_ramp1 (
      .i_ref_clk     (i_ref_clk),
      .i_rst_n       (i_rst_n),
      .i_flash       (flash_mode),
      .i_low_batt    (low_batt),
      .i_block_flash (st.low_battery_config[4]),
      .i_thermal_low (st.ramp_indicator_config[7] && i_tj_over_130),
      .i_thermal_off (!st.ramp_indicator_config[7] && i_tj_over_150),
      .i_tx_mask     (i_tx_mask),
      .i_step_sel    (st.ramp_indicator_config[6:4]),
      .i_target      (st.chan1_flash_level),
      .i_masked      (st.chan1_masked_flash_level),
      .o_level       (lvl1),
      .o_minimum     (min1)
   );
   flr_ramp u_ramp2 (
      .i_ref_clk     (i_ref_clk),
      .i_rst_n       (i_rst_n),
      .i_flash       (flash_mode),
      .i_low_batt    (low_batt),
      .i_block_flash (st.low_battery_config[4]),
      .i_thermal_low (st.ramp_indicator_config[7] && i_tj_over_130),
      .i_thermal_off (!st.ramp_indicator_config[7] && i_tj_over_150),
      .i_tx_mask     (i_tx_mask),
      .i_step_sel    (st.ramp_indicator_config[6:4]),
      .i_target      (st.chan2_flash_level),
      .i_masked      (st.chan2_masked_flash_level),
      .o_level       (lvl2),
      .o_minimum     ()
   );

   // Indicator PWM runs only in indicator mode.
   flr_pwm u_pwm (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_enable  (i_led_mode_sel == `FLR_MODE_INDICATOR),
      .i_duty    (st.ramp_indicator_config[1:0]),
      .o_pwm     (o_indicator_pwm)
   );

   // Readback: channel 1 reports the actual and minimum flash codes.
   always_comb begin
      actual_flash_code  = flash_mode ? lvl1 : `FLR_RST_READBACK;
      minimum_flash_code = min1;
   end

   // Register writes and registered read data.
   always_comb begin
      next_st = st;
      if (i_wr_en) begin
         case (i_addr)
            `FLR_ADDR_LOW_BATT:   next_st.low_battery_config       = i_wr_data;
            `FLR_ADDR_RAMP_IND:   next_st.ramp_indicator_config    = i_wr_data;
            `FLR_ADDR_CH1_FLASH:  next_st.chan1_flash_level        = i_wr_data;
            `FLR_ADDR_CH2_FLASH:  next_st.chan2_flash_level        = i_wr_data;
            `FLR_ADDR_CH1_MASKED: next_st.chan1_masked_flash_level = i_wr_data;
            `FLR_ADDR_CH2_MASKED: next_st.chan2_masked_flash_level = i_wr_data;
            // Readback and unmapped addresses ignore writes.
            default: next_st = st;
         endcase
      end
      if (i_rd_en) begin
         case (i_addr)
            `FLR_ADDR_LOW_BATT:   next_st.rd_data = st.low_battery_config;
            `FLR_ADDR_RAMP_IND:   next_st.rd_data = st.ramp_indicator_config;
            `FLR_ADDR_CH1_FLASH:  next_st.rd_data = st.chan1_flash_level;
            `FLR_ADDR_CH2_FLASH:  next_st.rd_data = st.chan2_flash_level;
            `FLR_ADDR_CH1_MASKED: next_st.rd_data = st.chan1_masked_flash_level;
            `FLR_ADDR_CH2_MASKED: next_st.rd_data = st.chan2_masked_flash_level;
            `FLR_ADDR_ACTUAL:     next_st.rd_data = actual_flash_code;
            `FLR_ADDR_MINIMUM:    next_st.rd_data = minimum_flash_code;
            default:              next_st.rd_data = 8'h00;
         endcase
      end
   end

   // State register with documented reset values.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st.low_battery_config       <= `FLR_RST_LOW_BATT;
         st.ramp_indicator_config    <= `FLR_RST_RAMP_IND;
         st.chan1_flash_level        <= `FLR_RST_LEVEL;
         st.chan2_flash_level        <= `FLR_RST_LEVEL;
         st.chan1_masked_flash_level <= `FLR_RST_LEVEL;
         st.chan2_masked_flash_level <= `FLR_RST_LEVEL;
         st.rd_data                  <= `FLR_RST_READBACK;
      end else begin
         st <= next_st;
      end
   end

   // Analog-facing decode.
   assign o_battery_threshold_sel = st.low_battery_config[7:5];
   assign o_low_batt_active       = low_batt;
   assign o_input_current_limit   = st.low_battery_config[3:0];
   assign o_input_limit_enable    = st.low_battery_config[3:0] < `FLR_ILIM_OFF;
   assign o_headroom_threshold    = st.ramp_indicator_config[3:2];
   assign o_chan1_drive           = lvl1;
   assign o_chan2_drive           = lvl2;
   assign o_rd_data               = st.rd_data;
endmodule : flr_regs

// ==== tb/flr_regs_asserts.sv ====
// Port checker for the flash LED configuration register bank.
`timescale 1ns/100ps
module flr_chk (
   input wire logic       i_ref_clk,
   input wire logic       i_rst_n,
   input wire logic       i_wr_en,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic [1:0] i_led_mode_sel,
   input wire logic       i_tx_mask,
   input wire logic       i_vin_below_thresh,
   input wire logic       i_tj_over_150,
   input wire logic [2:0] o_battery_threshold_sel,
   input wire logic       o_low_batt_active,
   input wire logic [3:0] o_input_current_limit,
   input wire logic       o_input_limit_enable,
   input wire logic [1:0] o_headroom_threshold,
   input wire logic [7:0] o_chan1_drive,
   input wire logic [7:0] o_chan2_drive,
   input wire logic       o_indicator_pwm
);
   logic [11:0] hi_cnt; // Length of the present indicator high run.
   logic        calm;   // Flash mode held with no mask edge or over-150 C event last cycle.
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   // Helper state; a mask edge may legally retarget the ramp, so it is excluded.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hi_cnt <= 12'h000;
         calm   <= 1'b0;
      end else begin
         hi_cnt <= o_indicator_pwm ? hi_cnt + 12'h001 : 12'h000;
         calm   <= (i_led_mode_sel == 2'h3) && !i_tj_over_150 && $stable(i_tx_mask);
      end
   end
   a_limit_off: assert property (
      o_input_limit_enable == (o_input_current_limit < 4'hC)) else $error("limit enable wrong");
   a_batt_gate: assert property (
      o_low_batt_active == (i_vin_below_thresh && (o_battery_threshold_sel != 3'h7)))
      else $error("low supply gate wrong");
   a_limit_write: assert property (
      i_wr_en && i_addr == 8'h04 |=> {o_battery_threshold_sel, 1'b0, o_input_current_limit}
      == ($past(i_wr_data) & 8'hEF)) else $error("supply register fields wrong");
   a_headroom_write: assert property (
      i_wr_en && i_addr == 8'h05 |=> o_headroom_threshold == 2'($past(i_wr_data) >> 2))
      else $error("headroom field wrong");
   a_idle_dark: assert property (
      (i_led_mode_sel != 2'h3)[*3] |-> o_chan1_drive == 8'h00 && o_chan2_drive == 8'h00)
      else $error("drive outside flash mode");
   a_pwm_quiet: assert property (
      (i_led_mode_sel != 2'h1)[*3] |-> !o_indicator_pwm) else $error("pwm outside indicator");
   a_pwm_width: assert property (
      $fell(o_indicator_pwm) && i_led_mode_sel == 2'h1 && $past(i_led_mode_sel) == 2'h1
      |-> hi_cnt inside {12'h1F0, 12'h2E8, 12'h3E0, 12'h4D8}) else $error("pwm width wrong");
   a_ramp_step: assert property (
      calm && i_led_mode_sel == 2'h3 && !i_tj_over_150 && $stable(i_tx_mask)
      |-> (o_chan1_drive - $past(o_chan1_drive)) inside {8'h00, 8'h01, 8'hFF})
      else $error("ramp moved more than one code");
   c_supply_write: cover property (i_wr_en && i_addr == 8'h04);
   c_pwm_pulse: cover property ($fell(o_indicator_pwm));
   c_ramp_top: cover property (o_chan1_drive == 8'h04);
endmodule : flr_chk
bind flr_regs flr_chk flr_chk_inst (.i_ref_clk, .i_rst_n, .i_wr_en, .i_addr, .i_wr_data,
   .i_led_mode_sel, .i_tx_mask, .i_vin_below_thresh, .i_tj_over_150, .o_battery_threshold_sel,
   .o_low_batt_active, .o_input_current_limit, .o_input_limit_enable, .o_headroom_threshold,
   .o_chan1_drive, .o_chan2_drive, .o_indicator_pwm);

// ==== tb/flr_host.sv ====
// Host model that reaches the register bank through its strobes.
`timescale 1ns/100ps
module flr_host (
   input  wire logic       i_ref_clk,  // Bank clock.
   input  wire logic [7:0] i_rd_data,  // Read data from the bank.
   output logic            o_wr_en,    // Write strobe.
   output logic            o_rd_en,    // Read strobe.
   output logic [7:0]      o_addr,     // Register address.
   output logic [7:0]      o_wr_data   // Write data.
);
   initial begin
      o_wr_en   = 1'b0;
      o_rd_en   = 1'b0;
      o_addr    = 8'hFF;
      o_wr_data = 8'hFF;
   end
   // One write; the idle bus is scrambled so stale values never look valid.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      #1;
      o_wr_en   = 1'b1;
      o_addr    = a;
      o_wr_data = d;
      @(posedge i_ref_clk);
      #1;
      o_wr_en   = 1'b0;
      o_addr    = ~a;
      o_wr_data = ~d;
   endtask : wr
   // One read; data is registered at the edge after the strobe.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_ref_clk);
      #1;
      o_rd_en = 1'b1;
      o_addr  = a;
      @(posedge i_ref_clk);
      #1;
      o_rd_en = 1'b0;
      o_addr  = ~a;
      d       = i_rd_data;
   endtask : rd
endmodule : flr_host

// ==== tb/test_flr_regs.sv ====
// Self-checking bench for the flash LED configuration register bank.
`timescale 1ns/100ps
module test_flr_regs
   import flr_pkg::*;
;
   logic       i_ref_clk, i_rst_n, wr_en, rd_en, tx, vin_low, hot150, hot130, lba, lim_en, pwm;
   logic [7:0] addr, wr_data, rd_data, ch1, ch2;
   logic [1:0] mode;
   logic [2:0] thr;
   int         err_total, n_checks, cyc, hi;
   // Reset image of offsets 04 to 0B.
   logic [7:0] rst_tab [8] = '{8'hF4, 8'h14, 8'h33, 8'h33, 8'h33, 8'h33, 8'h00, 8'h00};
   flr_regs flr_regs_inst (.i_ref_clk, .i_rst_n, .i_wr_en(wr_en), .i_rd_en(rd_en),
      .i_addr(addr), .i_wr_data(wr_data), .o_rd_data(rd_data), .i_led_mode_sel(mode),
      .i_tx_mask(tx), .i_vin_below_thresh(vin_low), .i_tj_over_130(hot130),
      .i_tj_over_150(hot150), .o_battery_threshold_sel(thr), .o_low_batt_active(lba),
      .o_input_current_limit(), .o_input_limit_enable(lim_en), .o_headroom_threshold(),
      .o_chan1_drive(ch1), .o_chan2_drive(ch2), .o_indicator_pwm(pwm));
   flr_host flr_host_inst (.i_ref_clk, .i_rd_data(rd_data), .o_wr_en(wr_en),
      .o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wr_data));
   initial begin
      i_ref_clk = 1'b0;
      forever #4 i_ref_clk = ~i_ref_clk;
   end
   task automatic give_verdict;
      if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      flr_host_inst.rd(a, d);
      chk(16'(d), 16'(exp));
   endtask : rchk
   // Waits a bounded time for channel 1 to reach a code.
   task automatic wait1(input logic [7:0] exp);
      for (int k = 0; k < 1200 && ch1 !== exp; k++) @(posedge i_ref_clk);
      #1;
      chk(16'(ch1), 16'(exp));
   endtask : wait1
   // A hang counts as a mismatch.
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 50000) begin
         err_total++;
         give_verdict();
      end
   end
   initial begin
      {i_rst_n, tx, vin_low, hot150, hot130, mode} = '0;
      repeat (3) @(posedge i_ref_clk);
      #1;
      i_rst_n = 1'b1;
      for (int a = 0; a < 8; a++) rchk(8'h04 + 8'(a), rst_tab[a]); // Reset image.
      rchk(8'h0C, 8'h00); // Unmapped offset reads zero.
      for (int a = 4; a < 12; a++) flr_host_inst.wr(8'(a), 8'hA0 | 8'(a));
      for (int a = 4; a < 12; a++) rchk(8'(a), a < 10 ? 8'hA0 | 8'(a) : 8'h00);
      for (int c = 0; c < 16; c++) begin
         vin_low = c[0];
         flr_host_inst.wr(8'h04, 8'(c));
         chk(16'(lim_en), 16'(c < 12)); // Limit codes and the off code.
         chk(16'(lba), 16'(c[0])); // Lowest threshold passes the comparator.
      end
      flr_host_inst.wr(8'h04, 8'hE0);
      chk(16'(lba), 16'h0000); // Threshold code 111 disables it.
      flr_host_inst.wr(8'h05, 8'h70);
      for (int a = 6; a < 10; a++) flr_host_inst.wr(8'(a), 8'(10 - a));
      vin_low = 1'b0;
      mode = 2'h3;
      wait1(8'h04); // Channel 1 ramps to its flash code.
      chk(16'(ch2), 16'h0003); // Channel 2 flash code.
      rchk(8'h0A, 8'h04); // Actual level readback.
      tx = 1'b1;
      wait1(8'h02); // Masked code on channel 1.
      chk(16'(ch2), 16'h0001); // Masked code on channel 2.
      tx = 1'b0;
      wait1(8'h04); // Back to the flash code once unmasked.
      flr_host_inst.wr(8'h05, 8'hF0);
      hot130 = 1'b1;
      wait1(8'h02); // Adaptive thermal falls back to the masked code.
      hot130 = 1'b0;
      flr_host_inst.wr(8'h05, 8'h70);
      wait1(8'h04); // Flash code again once cool.
      flr_host_inst.wr(8'h04, 8'h1C);
      vin_low = 1'b1;
      wait1(8'h02); // Low supply pulls the level down.
      vin_low = 1'b0;
      flr_host_inst.wr(8'h0B, 8'hFF);
      rchk(8'h0B, 8'h02); // Lowest level kept, write ignored.
      hot150 = 1'b1;
      repeat (3) @(posedge i_ref_clk);
      #1;
      chk(16'(ch1), 16'h0000); // Overheat shuts the drive off.
      mode = 2'h0;
      hot150 = 1'b0;
      vin_low = 1'b1;
      repeat (4) @(posedge i_ref_clk);
      #1;
      mode = 2'h3;
      repeat (600) @(posedge i_ref_clk);
      #1;
      chk(16'(ch1), 16'h0000); // Low supply at flash start blocks it.
      mode = 2'h1;
      vin_low = 1'b0;
      for (int d = 0; d < 4; d++) begin
         flr_host_inst.wr(8'h05, 8'h70 | 8'(d));
         repeat (3968) @(posedge i_ref_clk);
         hi = 0;
         repeat (3968) begin
            @(posedge i_ref_clk);
            #1;
            hi += int'(pwm === 1'b1);
         end
         chk(16'(hi), 16'((2 + d) * 248)); // Duty per period.
      end
      give_verdict();
   end
endmodule : test_flr_regs
